// ### rtl/arpd_pkg.sv
/*
 * Shared constants for the converter command link: timing counts, command
 * word layout, reset values and the host controller's register map.
 * Assumes a single 40 MHz system clock on both ends of the link.
 */
// Functional notes
// - Prefix 01, address 001 arms DAC write
// - Next word: skip two bits, load ten
// - Prefix 01, address 011 arms DAC readback
// - Next access sends 0000, DAC, 00 on A
// - Readback ignores command input, B keeps data
// - DAC level resets to 0x3FF
// - Power-down enters at twelfth falling edge
// - Clearing bit wakes; sleep keeps command bits
// - Deep or nap entry aborts running conversion
// - Deep: off within 2us, awake 1us after
// - Nap: off within 200ns, back in 3 clocks
// - Auto-nap sleeps within 200ns after each conversion
// - Auto-nap: start wakes, six clocks, 19 total
// - Address 101 resets all; link back after 500ns
// - Static input over four clocks picks input pair
// - Host holds command input static when idle
// - Mode pins pick channel source and lanes
package arpd_pkg;
	// Clock rate and printed times
	localparam int CLK_MHZ = 40;
	localparam int DEEP_ENTER_NS = 2000;
	localparam int DEEP_WAKE_NS = 1000;
	localparam int NAP_ENTER_NS = 200;
	localparam int RESET_HOLD_NS = 500;
	// Derived cycle counts: "within" rounds down, "after" rounds up
	localparam int DEEP_ENTER_CYC = DEEP_ENTER_NS * CLK_MHZ / 1000;
	localparam int DEEP_WAKE_CYC = (DEEP_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int NAP_ENTER_CYC = NAP_ENTER_NS * CLK_MHZ / 1000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
	// Counts in converter clocks
	localparam int NAP_WAKE_CLKS = 3;
	localparam int AN_WAKE_CLKS = 6;
	localparam int AN_CYCLE_CLKS = 19;
	localparam int CONV_CLKS = 16;
	localparam int LEGACY_CLKS = 4;
	localparam int APPLY_FALL = 12;
	localparam int ACC_FALLS = 16;
	localparam int HOST_FALLS = ACC_FALLS + 1;
	// Command word layout, sent most significant bit first
	localparam int CMD_W = 12;
	localparam int PFX_LSB = 10;
	localparam int ADDR_LSB = 7;
	localparam int DP_BIT = 4;
	localparam int NAP_BIT = 3;
	localparam int AN_BIT = 2;
	localparam int CH_LSB = 0;
	localparam logic [1:0] PFX_CFG = 2'h0;
	localparam logic [1:0] PFX_DAC = 2'h1;
	localparam logic [2:0] ADDR_CFG = 3'h0;
	localparam logic [2:0] ADDR_DAC_WR = 3'h1;
	localparam logic [2:0] ADDR_DAC_RD = 3'h3;
	localparam logic [2:0] ADDR_RESET = 3'h5;
	// Data widths and reset values
	localparam int DAC_W = 10;
	localparam int RES_W = 12;
	localparam int OUT_W = 16;
	localparam logic [9:0] DAC_RESET = 10'h3ff;
	// Host register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RX_A = 8'h0c;
	localparam logic [7:0] REG_RX_B = 8'h10;
	localparam logic [7:0] REG_CONV = 8'h14;
endpackage

// ### rtl/arpd_link_if.sv
/*
 * Serial link between host controller and converter command logic.
 * Assumes the bench resolves the channel B lane from its enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface arpd_link_if;
	logic sclk; // Converter clock, made by the host
	logic rd_strobe; // Access strobe
	logic convert_start; // Conversion start
	logic serial_cmd_in; // Command bits
	logic chan_select_pin; // Manual or automatic channel choice
	logic output_lane_pin; // Both lanes or lane A only
	logic serial_out_a; // Lane A data
	logic serial_out_b; // Lane B data
	logic serial_out_b_oe; // Lane B driven
	modport device (
		input sclk, rd_strobe, convert_start, serial_cmd_in, chan_select_pin, output_lane_pin,
		output serial_out_a, serial_out_b, serial_out_b_oe
	);
	modport host (
		output sclk, rd_strobe, convert_start, serial_cmd_in, chan_select_pin, output_lane_pin,
		input serial_out_a, serial_out_b, serial_out_b_oe
	);
endinterface
`default_nettype wire

// ### rtl/arpd_device.sv
/*
 * Converter command logic: serial command decode, reference level
 * register, power-down sequencing, command reset and conversion timing.
 * Assumes the host drives the link pins; all pins are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module arpd_device (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link to the host controller
	arpd_link_if.device link,
	// Analog core results
	input wire logic [arpd_pkg::RES_W-1:0] sample_a_i,
	input wire logic [arpd_pkg::RES_W-1:0] sample_b_i,
	// Core status
	output logic [arpd_pkg::DAC_W-1:0] ref_level_out_o,
	output logic bias_on_o,
	output logic low_power_o,
	output logic busy_o,
	output logic input_pair_o,
	output logic core_reset_o
);
	typedef enum logic [1:0] {PWR_ON, PWR_ENTER, PWR_OFF, PWR_WAKE} arpd_pwr_e;

	logic [5:0] pin_meta_reg; // First synchroniser stage
	logic [5:0] pin_sync_reg; // Second synchroniser stage
	logic sclk_prev_reg;
	logic conv_prev_reg;
	logic soft_rst_reg; // Command reset pulse
	logic [4:0] hold_cnt_reg; // Link quiet time after command reset
	logic acc_active_reg;
	logic [4:0] fall_cnt_reg;
	logic [arpd_pkg::CMD_W-1:0] cmd_shift_reg;
	logic cur_wr_reg; // This access carries DAC data
	logic cur_rd_reg; // This access is a DAC readback
	logic dac_wr_pend_reg;
	logic dac_rd_pend_reg;
	logic dp_reg;
	logic nap_reg;
	logic an_reg;
	logic [1:0] chan_reg;
	logic [arpd_pkg::DAC_W-1:0] dac_level_reg;
	logic [arpd_pkg::OUT_W-1:0] out_a_reg;
	logic [arpd_pkg::OUT_W-1:0] out_b_reg;
	logic alt_reg; // Lane A alternates channels in single-lane mode
	logic b_oe_reg;
	arpd_pwr_e pwr_state;
	logic [6:0] pwr_cnt_reg;
	logic pwr_by_fall_reg; // Wake count runs on converter clocks
	logic why_deep_reg;
	logic why_auto_reg;
	logic wake_conv_reg; // Auto-nap wake then convert
	logic conv_active_reg;
	logic [4:0] conv_cnt_reg;
	logic [2:0] leg_cnt_reg;
	logic leg_first_reg;
	logic leg_same_reg;
	logic pair_reg;
	logic [arpd_pkg::RES_W-1:0] res_a_reg;
	logic [arpd_pkg::RES_W-1:0] res_b_reg;
	logic res_pair_reg;
	logic bias_on_reg;
	logic low_power_reg;

	// Synchronised pins and their edges
	wire sclk_s = pin_sync_reg[0];
	wire rd_s = pin_sync_reg[1];
	wire conv_s = pin_sync_reg[2];
	wire sdi_s = pin_sync_reg[3];
	wire auto_s = pin_sync_reg[4];
	wire lane_s = pin_sync_reg[5];
	wire fall = sclk_prev_reg & ~sclk_s;
	wire conv_rise = conv_s & ~conv_prev_reg;
	wire core_rst = rst_i | soft_rst_reg;

	// Command decode at the twelfth falling edge
	wire acc_start = fall & ~acc_active_reg & rd_s & (hold_cnt_reg == 5'h00);
	wire apply_now = fall & acc_active_reg & (fall_cnt_reg == 5'(arpd_pkg::APPLY_FALL - 1));
	wire [arpd_pkg::CMD_W-1:0] cmd_word = {cmd_shift_reg[arpd_pkg::CMD_W-2:0], sdi_s};
	wire [1:0] pfx = cmd_word[arpd_pkg::PFX_LSB+:2];
	wire [2:0] addr = cmd_word[arpd_pkg::ADDR_LSB+:3];
	wire plain = apply_now & ~cur_rd_reg & ~cur_wr_reg;
	wire do_cfg = plain & (pfx == arpd_pkg::PFX_CFG) & (addr == arpd_pkg::ADDR_CFG);
	wire pwr_tick = pwr_by_fall_reg ? fall : 1'b1;
	wire wake_done = (pwr_state == PWR_WAKE) & pwr_tick & (pwr_cnt_reg == 7'h00);
	wire pd_req = dp_reg | nap_reg;
	wire conv_go = (conv_rise & (pwr_state == PWR_ON) & ~conv_active_reg & ~pd_req)
		| (wake_done & wake_conv_reg);
	wire conv_done = conv_active_reg & fall & (conv_cnt_reg == 5'h01);

	// Output words with channel and converter indicators
	wire [arpd_pkg::RES_W-1:0] res_sel = (lane_s & alt_reg) ? res_b_reg : res_a_reg;
	wire ind_hi = auto_s & res_pair_reg;
	wire [arpd_pkg::OUT_W-1:0] word_a = {ind_hi, lane_s & alt_reg, res_sel, 2'h0};
	wire [arpd_pkg::OUT_W-1:0] word_b = {ind_hi, 1'b0, res_b_reg, 2'h0};

	// Two-stage synchronisers and edge history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_reg <= 6'h00;
			pin_sync_reg <= 6'h00;
			sclk_prev_reg <= 1'b0;
			conv_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= {link.output_lane_pin, link.chan_select_pin, link.serial_cmd_in,
				link.convert_start, link.rd_strobe, link.sclk};
			pin_sync_reg <= pin_meta_reg;
			sclk_prev_reg <= sclk_s;
			conv_prev_reg <= conv_s;
		end
	end

	// Command reset and the quiet time that follows it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_rst_reg <= 1'b0;
			hold_cnt_reg <= 5'h00;
		end else begin
			soft_rst_reg <= plain & (addr == arpd_pkg::ADDR_RESET);
			if (soft_rst_reg) begin
				hold_cnt_reg <= 5'(arpd_pkg::RESET_HOLD_CYC);
			end else if (hold_cnt_reg != 5'h00) begin
				hold_cnt_reg <= hold_cnt_reg - 5'h01;
			end
		end
	end

	// Access framing: bits taken on falling converter clock edges
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			acc_active_reg <= 1'b0;
			fall_cnt_reg <= 5'h00;
			cmd_shift_reg <= 12'h000;
			cur_wr_reg <= 1'b0;
			cur_rd_reg <= 1'b0;
		end else if (acc_start) begin
			acc_active_reg <= 1'b1;
			fall_cnt_reg <= 5'h01;
			cmd_shift_reg <= {11'h000, sdi_s};
			cur_wr_reg <= dac_wr_pend_reg;
			cur_rd_reg <= dac_rd_pend_reg;
		end else if (fall & acc_active_reg) begin
			fall_cnt_reg <= fall_cnt_reg + 5'h01;
			cmd_shift_reg <= cmd_word;
			if (fall_cnt_reg == 5'(arpd_pkg::ACC_FALLS - 1)) begin
				acc_active_reg <= 1'b0;
			end
		end
	end

	// Two-access sequences armed by a DAC command
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			dac_wr_pend_reg <= 1'b0;
			dac_rd_pend_reg <= 1'b0;
		end else if (acc_start) begin
			dac_wr_pend_reg <= 1'b0;
			dac_rd_pend_reg <= 1'b0;
		end else if (plain & (pfx == arpd_pkg::PFX_DAC)) begin
			dac_wr_pend_reg <= (addr == arpd_pkg::ADDR_DAC_WR);
			dac_rd_pend_reg <= (addr == arpd_pkg::ADDR_DAC_RD);
		end
	end

	// Command register bits, applied only once the word is whole
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			dp_reg <= 1'b0;
			nap_reg <= 1'b0;
			an_reg <= 1'b0;
			chan_reg <= 2'h0;
		end else if (do_cfg) begin
			dp_reg <= cmd_word[arpd_pkg::DP_BIT];
			nap_reg <= cmd_word[arpd_pkg::NAP_BIT];
			an_reg <= cmd_word[arpd_pkg::AN_BIT];
			chan_reg <= cmd_word[arpd_pkg::CH_LSB+:2];
		end
	end

	// Reference level register
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			dac_level_reg <= arpd_pkg::DAC_RESET;
		end else if (apply_now & cur_wr_reg) begin
			dac_level_reg <= cmd_word[arpd_pkg::DAC_W-1:0];
		end
	end

	// Output lanes, loaded at access start and shifted per falling edge
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			out_a_reg <= 16'h0000;
			out_b_reg <= 16'h0000;
			alt_reg <= 1'b0;
			b_oe_reg <= 1'b0;
		end else begin
			b_oe_reg <= ~lane_s;
			if (acc_start) begin
				// Readback replaces lane A; lane B keeps conversion data
				out_a_reg <= dac_rd_pend_reg ? {4'h0, dac_level_reg, 2'h0} : word_a;
				out_b_reg <= word_b;
				alt_reg <= (lane_s & ~dac_rd_pend_reg) ? ~alt_reg : alt_reg;
			end else if (fall & acc_active_reg) begin
				out_a_reg <= {out_a_reg[arpd_pkg::OUT_W-2:0], 1'b0};
				out_b_reg <= {out_b_reg[arpd_pkg::OUT_W-2:0], 1'b0};
			end
		end
	end

	// Power sequencing; sleeping never touches the command bits
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			pwr_state <= PWR_ON;
			pwr_cnt_reg <= 7'h00;
			pwr_by_fall_reg <= 1'b0;
			why_deep_reg <= 1'b0;
			why_auto_reg <= 1'b0;
			wake_conv_reg <= 1'b0;
		end else begin
			case (pwr_state)
				PWR_ON: begin
					wake_conv_reg <= 1'b0;
					if (pd_req) begin
						pwr_state <= PWR_ENTER;
						why_deep_reg <= dp_reg;
						why_auto_reg <= 1'b0;
						pwr_cnt_reg <= dp_reg ? 7'(arpd_pkg::DEEP_ENTER_CYC - 1)
							: 7'(arpd_pkg::NAP_ENTER_CYC - 1);
					end else if (conv_done & an_reg) begin
						pwr_state <= PWR_ENTER;
						why_deep_reg <= 1'b0;
						why_auto_reg <= 1'b1;
						pwr_cnt_reg <= 7'(arpd_pkg::NAP_ENTER_CYC - 1);
					end
				end
				PWR_ENTER: begin
					if (pwr_cnt_reg == 7'h00) begin
						pwr_state <= PWR_OFF;
					end else begin
						pwr_cnt_reg <= pwr_cnt_reg - 7'h01;
					end
				end
				PWR_OFF: begin
					pwr_by_fall_reg <= 1'b1;
					if (why_deep_reg & ~dp_reg) begin
						pwr_state <= PWR_WAKE;
						pwr_by_fall_reg <= 1'b0;
						pwr_cnt_reg <= 7'(arpd_pkg::DEEP_WAKE_CYC - 1);
					end else if (~why_deep_reg & ~why_auto_reg & ~nap_reg) begin
						pwr_state <= PWR_WAKE;
						pwr_cnt_reg <= 7'(arpd_pkg::NAP_WAKE_CLKS - 1);
					end else if (why_auto_reg & (conv_rise | ~an_reg)) begin
						pwr_state <= PWR_WAKE;
						wake_conv_reg <= conv_rise;
						pwr_cnt_reg <= conv_rise ? 7'(arpd_pkg::AN_WAKE_CLKS - 1)
							: 7'(arpd_pkg::NAP_WAKE_CLKS - 1);
					end
				end
				PWR_WAKE: begin
					if (wake_done) begin
						pwr_state <= PWR_ON;
					end else if (pwr_tick) begin
						pwr_cnt_reg <= pwr_cnt_reg - 7'h01;
					end
				end
				default: pwr_state <= PWR_ON;
			endcase
		end
	end

	// Conversion timer, aborted by deep or nap entry
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			conv_active_reg <= 1'b0;
			conv_cnt_reg <= 5'h00;
		end else if ((pwr_state == PWR_ON) & pd_req) begin
			conv_active_reg <= 1'b0;
		end else if (conv_go) begin
			conv_active_reg <= 1'b1;
			conv_cnt_reg <= wake_conv_reg
				? 5'(arpd_pkg::AN_CYCLE_CLKS - arpd_pkg::AN_WAKE_CLKS)
				: 5'(arpd_pkg::CONV_CLKS);
		end else if (conv_done) begin
			conv_active_reg <= 1'b0;
		end else if (conv_active_reg & fall) begin
			conv_cnt_reg <= conv_cnt_reg - 5'h01;
		end
	end

	// Input pair choice: legacy static input, command bits or automatic
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			leg_cnt_reg <= 3'h0;
			leg_first_reg <= 1'b0;
			leg_same_reg <= 1'b0;
			pair_reg <= 1'b0;
		end else if (conv_go) begin
			leg_cnt_reg <= 3'(arpd_pkg::LEGACY_CLKS);
			leg_first_reg <= sdi_s;
			leg_same_reg <= 1'b1;
		end else if (fall & (leg_cnt_reg != 3'h0)) begin
			leg_cnt_reg <= leg_cnt_reg - 3'h1;
			leg_same_reg <= leg_same_reg & (sdi_s == leg_first_reg);
			if ((leg_cnt_reg == 3'h1) & ~auto_s) begin
				// A static input overrides the command channel bits
				pair_reg <= (leg_same_reg & (sdi_s == leg_first_reg))
					? leg_first_reg : chan_reg[0];
			end
		end else if (conv_done & auto_s) begin
			pair_reg <= ~pair_reg;
		end
	end

	// Results captured at the end of each conversion
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			res_a_reg <= 12'h000;
			res_b_reg <= 12'h000;
			res_pair_reg <= 1'b0;
		end else if (conv_done) begin
			res_a_reg <= sample_a_i;
			res_b_reg <= sample_b_i;
			res_pair_reg <= pair_reg;
		end
	end

	// Registered power status
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			bias_on_reg <= 1'b1;
			low_power_reg <= 1'b0;
		end else begin
			bias_on_reg <= (pwr_state != PWR_OFF);
			low_power_reg <= (pwr_state == PWR_OFF);
		end
	end

	// Ports straight from flip-flops
	assign link.serial_out_a = out_a_reg[arpd_pkg::OUT_W-1];
	assign link.serial_out_b = out_b_reg[arpd_pkg::OUT_W-1];
	assign link.serial_out_b_oe = b_oe_reg;
	assign ref_level_out_o = dac_level_reg;
	assign bias_on_o = bias_on_reg;
	assign low_power_o = low_power_reg;
	assign busy_o = conv_active_reg;
	assign input_pair_o = pair_reg;
	assign core_reset_o = soft_rst_reg;
endmodule
`default_nettype wire

// ### rtl/arpd_host.sv
/*
 * Host controller for the converter link: makes the converter clock,
 * sends command words and strobes, and gathers both output lanes.
 * Assumes software drives it as a classic Wishbone slave.
 */
`timescale 1ns/1ps
`default_nettype none
module arpd_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Link to the converter
	arpd_link_if.host link
);
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [1:0] ctrl_reg; // Mode pins
	logic [arpd_pkg::CMD_W-1:0] cmd_word_reg;
	logic cmd_pend_reg;
	logic conv_pend_reg;
	logic [2:0] div_reg;
	logic sclk_reg;
	logic active_reg;
	logic [4:0] fcnt_reg;
	logic [arpd_pkg::CMD_W-1:0] tx_reg;
	logic rd_reg;
	logic sdi_reg;
	logic convert_start_reg;
	logic [1:0] in_meta_reg;
	logic [1:0] in_sync_reg;
	logic [arpd_pkg::OUT_W-1:0] rx_a_reg;
	logic [arpd_pkg::OUT_W-1:0] rx_b_reg;
	logic rx_new_reg;

	// Bus strobes: a write takes effect on the acknowledging edge
	wire wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	wire busy = active_reg | cmd_pend_reg;
	wire rise_ev = (div_reg == 3'h7);
	wire fall_ev = (div_reg == 3'h3);
	wire start_frame = rise_ev & ~active_reg & cmd_pend_reg;
	wire cmd_wr = wr_fire & (wb_adr_i == arpd_pkg::REG_CMD) & (&wb_sel_i[1:0]) & ~busy;

	// Acknowledge one cycle after the request, for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
			case (wb_adr_i)
				arpd_pkg::REG_CTRL: rdata_reg <= {30'h0000_0000, ctrl_reg};
				arpd_pkg::REG_CMD: rdata_reg <= {20'h0_0000, cmd_word_reg};
				arpd_pkg::REG_STATUS: rdata_reg <= {30'h0000_0000, rx_new_reg, busy};
				arpd_pkg::REG_RX_A: rdata_reg <= {16'h0000, rx_a_reg};
				arpd_pkg::REG_RX_B: rdata_reg <= {16'h0000, rx_b_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Software registers and pending requests
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= 2'h0;
			cmd_word_reg <= 12'h000;
			cmd_pend_reg <= 1'b0;
			conv_pend_reg <= 1'b0;
		end else begin
			if (wr_fire & (wb_adr_i == arpd_pkg::REG_CTRL) & wb_sel_i[0]) begin
				ctrl_reg <= wb_dat_i[1:0];
			end
			if (cmd_wr) begin
				cmd_word_reg <= wb_dat_i[arpd_pkg::CMD_W-1:0];
				cmd_pend_reg <= 1'b1;
			end else if (start_frame) begin
				cmd_pend_reg <= 1'b0;
			end
			if (wr_fire & (wb_adr_i == arpd_pkg::REG_CONV) & wb_sel_i[0] & wb_dat_i[0]) begin
				conv_pend_reg <= 1'b1;
			end else if (rise_ev) begin
				conv_pend_reg <= 1'b0;
			end
		end
	end

	// Converter clock divider: eight system clocks per period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 3'h0;
			sclk_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 3'h1;
			if (rise_ev) begin
				sclk_reg <= 1'b1;
			end else if (fall_ev) begin
				sclk_reg <= 1'b0;
			end
		end
	end

	// Frame: strobe and bits change with the rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_reg <= 1'b0;
			fcnt_reg <= 5'h00;
			tx_reg <= 12'h000;
			rd_reg <= 1'b0;
			sdi_reg <= 1'b0;
			convert_start_reg <= 1'b0;
		end else begin
			if (rise_ev) begin
				convert_start_reg <= conv_pend_reg;
			end
			if (start_frame) begin
				active_reg <= 1'b1;
				fcnt_reg <= 5'h00;
				rd_reg <= 1'b1;
				sdi_reg <= cmd_word_reg[arpd_pkg::CMD_W-1];
				tx_reg <= {cmd_word_reg[arpd_pkg::CMD_W-2:0], 1'b0};
			end else if (rise_ev & active_reg) begin
				rd_reg <= 1'b0;
				sdi_reg <= tx_reg[arpd_pkg::CMD_W-1];
				tx_reg <= {tx_reg[arpd_pkg::CMD_W-2:0], 1'b0};
			end else if (rise_ev) begin
				sdi_reg <= 1'b0;
			end else if (fall_ev & active_reg) begin
				fcnt_reg <= fcnt_reg + 5'h01;
				if (fcnt_reg == 5'(arpd_pkg::HOST_FALLS - 1)) begin
					active_reg <= 1'b0;
				end
			end
		end
	end

	// Lane inputs: synchronised, then sampled on falls two to seventeen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_meta_reg <= 2'h0;
			in_sync_reg <= 2'h0;
			rx_a_reg <= 16'h0000;
			rx_b_reg <= 16'h0000;
			rx_new_reg <= 1'b0;
		end else begin
			in_meta_reg <= {link.serial_out_b, link.serial_out_a};
			in_sync_reg <= in_meta_reg;
			if (cmd_wr) begin
				rx_new_reg <= 1'b0;
			end
			if (fall_ev & active_reg & (fcnt_reg != 5'h00)) begin
				rx_a_reg <= {rx_a_reg[arpd_pkg::OUT_W-2:0], in_sync_reg[0]};
				rx_b_reg <= {rx_b_reg[arpd_pkg::OUT_W-2:0], in_sync_reg[1]};
				if (fcnt_reg == 5'(arpd_pkg::HOST_FALLS - 1)) begin
					rx_new_reg <= 1'b1;
				end
			end
		end
	end

	// Ports straight from flip-flops
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign link.sclk = sclk_reg;
	assign link.rd_strobe = rd_reg;
	assign link.convert_start = convert_start_reg;
	assign link.serial_cmd_in = sdi_reg;
	assign link.chan_select_pin = ctrl_reg[0];
	assign link.output_lane_pin = ctrl_reg[1];
endmodule
`default_nettype wire

// ### tb/arpd_asserts.sv
/*
 * Checker for the converter link signals.
 * Assumes instantiation beside the link interface.
 */
`timescale 1ns/1ps
`default_nettype none
module arpd_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link signals
	input wire logic sclk,
	input wire logic rd_strobe,
	input wire logic convert_start,
	input wire logic output_lane_pin,
	input wire logic serial_out_a,
	input wire logic serial_out_b_oe
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Cycles since the strobe was last high, saturating
	logic [7:0] gap_reg;
	// Gap counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_reg <= 8'hff;
		end else if (rd_strobe) begin
			gap_reg <= 8'h00;
		end else if (gap_reg != 8'hff) begin
			gap_reg <= gap_reg + 8'h01;
		end
	end
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("sclk high phase wrong");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
		else $error("sclk low phase wrong");
	AST_RD_LEN: assert property ($rose(rd_strobe) |-> rd_strobe [*8] ##1 !rd_strobe)
		else $error("strobe length wrong");
	AST_RD_ALIGN: assert property ($rose(rd_strobe) |-> $rose(sclk))
		else $error("strobe off sclk rise");
	AST_RD_GAP: assert property ($rose(rd_strobe) |-> gap_reg > 8'h70)
		else $error("frames too close");
	AST_CONV_LEN: assert property ($rose(convert_start) |-> convert_start [*8] ##1 !convert_start)
		else $error("start pulse length wrong");
	AST_LANE_OFF: assert property (output_lane_pin [*6] |-> !serial_out_b_oe)
		else $error("lane B driven in lane A mode");
	AST_RST_QUIET: assert property ($fell(rst_i) |-> !sclk && !rd_strobe && !serial_out_a && !serial_out_b_oe)
		else $error("link not quiet after reset");
	// Main scenarios reached
	cover property ($rose(rd_strobe));
	cover property ($rose(convert_start));
	cover property ($fell(serial_out_b_oe));
endmodule
`default_nettype wire

// ### tb/adc_ref_dac_powerdown_ctrl_test.sv
/*
 * Bench: host and converter joined by the link, driven over Wishbone.
 * Assumes a 40 MHz clock and the host register map of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_ref_dac_powerdown_ctrl_test;
	logic clk_i, rst_i, cyc, we; // Clock, reset, bus strobes
	logic [7:0] adr; // Bus address
	logic [31:0] wdat, rdat; // Bus data out and last read
	logic [31:0] dat_o; // Slave read data
	logic ack, b_oe; // Slave ack, lane B enable
	logic [9:0] ref_lvl; // Reference level
	logic bias, lowp, busy; // Core status
	logic pair, core_rst; // Input pair, command reset pulse
	int fails, checks_done; // Counters
	int n_rst; // Command reset pulses seen
	arpd_link_if link();
	assign b_oe = link.serial_out_b_oe;
	arpd_host u_arpd_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .link(link));
	arpd_device u_arpd_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.sample_a_i(12'h05a3), .sample_b_i(12'h03c7), .ref_level_out_o(ref_lvl),
		.bias_on_o(bias), .low_power_o(lowp), .busy_o(busy), .input_pair_o(pair),
		.core_reset_o(core_rst));
	arpd_asserts u_arpd_asserts (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk),
		.rd_strobe(link.rd_strobe), .convert_start(link.convert_start),
		.output_lane_pin(link.output_lane_pin), .serial_out_a(link.serial_out_a),
		.serial_out_b_oe(link.serial_out_b_oe));
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Count command reset pulses, one clock wide each
	always @(posedge clk_i) begin
		if (core_rst === 1'b1) begin
			n_rst <= n_rst + 1;
		end
	end
	// Watchdog
	initial begin
		#1500000;
		fails++;
		stop_test();
	end
	// Report and end
	task automatic stop_test();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// One classic Wishbone cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	// Send a command word and wait for the frame to end
	task automatic send(input logic [11:0] c);
		bus(1'b1, 8'h04, {20'h0_0000, c});
		do bus(1'b0, 8'h08, 32'h0000_0000); while (rdat[1] !== 1'b1);
	endtask
	task automatic t_reset();
		chk("ref", 32'h0000_03ff, 32'(ref_lvl));
		chk("bias", 32'h0000_0001, 32'(bias));
		chk("sdi idle", 32'h0000_0000, 32'(link.serial_cmd_in));
		bus(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rdat);
	endtask
	task automatic t_dac();
		bus(1'b1, 8'h14, 32'h0000_0001);
		wt(200);
		send(12'h0480);
		send(12'h0ea5);
		chk("ref", 32'h0000_02a5, 32'(ref_lvl));
		send(12'h0580);
		send(12'h0010);
		wt(80);
		// Last poll read: frame done, new lane words waiting
		chk("status", 32'h0000_0002, rdat);
		bus(1'b0, 8'h0c, 32'h0000_0000);
		chk("rx a", 32'h0000_0a94, rdat);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk("rx b", 32'h0000_0f1c, rdat);
		chk("sleep", 32'h0000_0000, 32'(lowp));
	endtask
	task automatic t_power(input logic [11:0] c);
		send(c);
		wt(80);
		chk("sleep", 32'h0000_0001, 32'(lowp));
		chk("bias", 32'h0000_0000, 32'(bias));
		send(12'h0000);
		wt(80);
		chk("wake", 32'h0000_0001, 32'(bias));
	endtask
	task automatic t_autonap();
		int n;
		// Auto-nap on, channel bit set: a static low input must still win
		send(12'h0005);
		wt(80);
		chk("sleep", 32'h0000_0000, 32'(lowp));
		bus(1'b1, 8'h14, 32'h0000_0001);
		while (busy !== 1'b1) @(posedge clk_i);
		while (busy !== 1'b0) @(posedge clk_i);
		wt(10);
		chk("sleep", 32'h0000_0001, 32'(lowp));
		chk("pair", 32'h0000_0000, 32'(pair));
		// Start from auto-nap: wake first, then a 13-clock conversion
		bus(1'b1, 8'h14, 32'h0000_0001);
		while (busy !== 1'b1) @(posedge clk_i);
		chk("sleep", 32'h0000_0000, 32'(lowp));
		n = 0;
		while (busy !== 1'b0) begin
			@(posedge clk_i);
			n++;
		end
		// Thirteen converter clocks of eight system clocks each
		chk("conv clocks", 32'h0000_0001, 32'(n > 32'h0000_0060 && n <= 32'h0000_0068));
		send(12'h0000);
	endtask
	task automatic t_cmd_reset();
		send(12'h0480);
		send(12'h007f);
		send(12'h0280);
		chk("ref", 32'h0000_03ff, 32'(ref_lvl));
		chk("core reset", 32'h0000_0001, 32'(n_rst));
		send(12'h0480);
		send(12'h0155);
		chk("ref", 32'h0000_0155, 32'(ref_lvl));
		bus(1'b1, 8'h00, 32'h0000_0002);
		wt(10);
		chk("b oe", 32'h0000_0000, 32'(b_oe));
		// Automatic channel choice: pair flips at the end of the conversion
		bus(1'b1, 8'h00, 32'h0000_0001);
		bus(1'b1, 8'h14, 32'h0000_0001);
		while (busy !== 1'b1) @(posedge clk_i);
		while (busy !== 1'b0) @(posedge clk_i);
		wt(2);
		chk("pair", 32'h0000_0001, 32'(pair));
	endtask
	// Main sequence
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		wt(3);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_dac();
		t_power(12'h0010);
		t_power(12'h0008);
		t_autonap();
		t_cmd_reset();
		stop_test();
	end
endmodule
`default_nettype wire
